// [sam_pkg.sv]
// Notes on behaviour
// R01 - In x16 mode eight banks come from three bank bits, rows from thirteen bits and columns from ten bits; the core keeps only the low ROW_IMPL row bits.
// R02 - In x32 mode columns come from nine bits, with rows and banks decoded as in x16 mode.
// R03 - The lowest column bit never travels on the command bus and is taken as zero, so bursts start on even columns.
// R04 - Row and column bit positions that the chosen width does not use are ignored.
// R05 - Each access moves one 4n-bit core word in one cycle, seen at the pins as four n-bit half-clock transfers.
// R06 - Each data pin carries two bits per clock, one per half, for reads and writes alike.
// R07 - Accesses run as bursts of a programmed length in a programmed order from the addressed column.
// R08 - While the tristate control is active every output is high impedance; otherwise the device runs normally.
// R09 - The tristate control defaults inactive through a pull-down and a fuse may invert its active level.
// R10 - The temperature alarm is high at or above 85 degrees C and low below it.
// R11 - The controller finishes initialization before issuing any normal read or write.
// R12 - Command/address halves are taken on both clock edges, chip select and clock enable on the rising edge only.
// R13 - A write byte whose mask is high alongside its data is not written; the mask is taken on both strobe edges.
package sam_pkg;
  localparam int BANK_BITS    = 3;
  localparam int ROW_BITS     = 13;
  localparam int COL_BITS_X16 = 10;
  localparam int COL_BITS_X32 = 9;
  localparam int CA_ROW_W     = 14;
  localparam int CA_COL_W     = 11;
  localparam int CWW          = COL_BITS_X16 - 2;
  localparam int DQ_MAX       = 32;
  localparam int LANE_MAX     = 4;
  localparam logic signed [7:0] HOT_LIMIT_C = 8'sh55;
  localparam logic [1:0] BL4  = 2'h1;
  localparam logic [1:0] BL8  = 2'h2;
  localparam logic [1:0] BL16 = 2'h3;
  localparam logic [1:0] CNT_RST   = 2'h0;
  localparam logic       READY_RST = 1'b0;
  localparam logic       FLAG_RST  = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } sam_state_type;

  // One command as both clock halves deliver it
  typedef struct packed {
    logic                  valid;
    logic                  cke;
    logic                  cs_n;
    logic                  write;
    logic [BANK_BITS-1:0]  bank;
    logic [CA_ROW_W-1:0]   row;
    logic [CA_COL_W-1:0]   col;
    logic [1:0]            bl;
    logic                  interleave;
  } sam_cmd_type;

  typedef struct packed {
    logic [DQ_MAX-1:0]   rise;
    logic [DQ_MAX-1:0]   fall;
    logic [LANE_MAX-1:0] mask_rise;
    logic [LANE_MAX-1:0] mask_fall;
  } sam_wbeat_type;

  typedef struct packed {
    logic [DQ_MAX-1:0] rise;
    logic [DQ_MAX-1:0] fall;
  } sam_rbeat_type;
endpackage

// [sam_core.sv]
`timescale 1ns/1ns
module sam_core #(
  parameter bit X32      = 1'b0,
  parameter int ROW_IMPL = 2,
  parameter int CW_IMPL  = 3
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Commands from the decoder
  input  wire sam_pkg::sam_cmd_type  cmd_in,
  output logic                       cmd_ready_out,
  // Write beats
  input  wire sam_pkg::sam_wbeat_type wr_beat_in,
  input  wire logic                  wr_valid_in,
  output logic                       wr_ready_out,
  // Read beats
  output sam_pkg::sam_rbeat_type     rd_beat_out,
  output logic                       rd_valid_out,
  input  wire logic                  rd_ready_in,
  output logic                       dq_oe_out,
  // Optional pins
  input  wire logic                  force_outputs_tristate_in,
  input  wire logic                  tristate_invert_fuse_in,
  input  wire logic [7:0]            die_temp_in,
  output logic                       over_temperature_flag_out,
  output logic                       over_temperature_flag_oe_out
);
  localparam int N     = X32 ? 32 : 16;
  localparam int LN    = N / 8;
  localparam int WW    = 4 * N;
  localparam int COLB  = X32 ? sam_pkg::COL_BITS_X32 : sam_pkg::COL_BITS_X16;
  localparam int IW    = sam_pkg::BANK_BITS + ROW_IMPL + CW_IMPL;
  localparam int DEPTH = 1 << IW;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; reset value 0 mirrors the pull-down
  logic [1:0]        hiz_sync;
  logic signed [7:0] temp_s1;
  logic signed [7:0] temp_s2;
  logic              hiz_active;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hiz_sync <= 2'h0;
      temp_s1  <= 8'sh00;
      temp_s2  <= 8'sh00;
    end else begin
      hiz_sync <= {hiz_sync[0], force_outputs_tristate_in};
      temp_s1  <= $signed(die_temp_in);
      temp_s2  <= temp_s1;
    end
  end
  assign hiz_active = hiz_sync[1] ^ tristate_invert_fuse_in; // [R09]

  ////////////////////////////////////////////////////////////////////////////
  // Burst controller
  sam_pkg::sam_state_type state, next_state;
  logic [1:0]                   k, next_k, wm1, next_wm1;
  logic                         ilv, next_ilv, spair, next_spair;
  logic [sam_pkg::BANK_BITS-1:0] bank, next_bank;
  logic [ROW_IMPL-1:0]          row, next_row;
  logic [sam_pkg::CWW-1:0]      colw, next_colw, waddr;
  logic [2*N-1:0]               hold_d, next_hold_d;
  logic [2*LN-1:0]              hold_m, next_hold_m;
  logic                         wr_half, next_wr_half, next_cmd_ready, next_wr_ready;
  logic                         cmd_take, wr_take, push, mem_we;
  logic [1:0]                   off;
  logic [IW-1:0]                mem_idx;
  logic [2*N-1:0]               bd;
  logic [2*LN-1:0]              bm;
  logic [WW-1:0]                wword, mem [DEPTH];
  logic [4*LN-1:0]              wmask;
  logic [1:0]                   fcnt, next_fcnt;

  assign cmd_take = cmd_ready_out && cmd_in.valid && cmd_in.cke && !cmd_in.cs_n; // [R12]
  assign wr_take  = state == sam_pkg::ST_WRITE && wr_ready_out && wr_valid_in;
  assign push     = state == sam_pkg::ST_READ && fcnt != 2'h2;
  assign mem_we   = wr_take && wr_half;
  // Burst order: wrap within the burst, sequential or interleaved
  assign off      = (ilv ? (colw[1:0] ^ k) : (colw[1:0] + k)) & wm1; // [R07]
  assign waddr    = (colw & ~sam_pkg::CWW'(wm1)) | sam_pkg::CWW'(off);
  assign mem_idx  = {bank, row, waddr[CW_IMPL-1:0]};
  assign bd       = {wr_beat_in.fall[N-1:0], wr_beat_in.rise[N-1:0]}; // [R06]
  assign bm       = {wr_beat_in.mask_fall[LN-1:0], wr_beat_in.mask_rise[LN-1:0]}; // [R13]
  // First beat lands in the addressed pair
  assign wword    = spair ? {hold_d, bd} : {bd, hold_d};
  assign wmask    = spair ? {hold_m, bm} : {bm, hold_m};

  always_comb begin
    next_state   = state;
    next_k       = k;
    next_wm1     = wm1;
    next_ilv     = ilv;
    next_spair   = spair;
    next_bank    = bank;
    next_row     = row;
    next_colw    = colw;
    next_hold_d  = hold_d;
    next_hold_m  = hold_m;
    next_wr_half = wr_half;
    unique case (state)
      sam_pkg::ST_IDLE: begin
        if (cmd_take) begin
          next_bank  = cmd_in.bank; // [R01]
          // Only the low implemented row bits index the array
          next_row   = cmd_in.row[ROW_IMPL-1:0]; // [R01] [R04]
          // Column bit 0 is never read; bits above COLB are ignored
          next_colw  = sam_pkg::CWW'(cmd_in.col[COLB-1:2]); // [R02] [R03] [R04]
          next_spair = cmd_in.col[1]; // [R03]
          next_wm1   = cmd_in.bl == sam_pkg::BL16 ? 2'h3 : (cmd_in.bl == sam_pkg::BL8 ? 2'h1 : 2'h0); // [R07]
          next_ilv   = cmd_in.interleave;
          next_k     = 2'h0;
          next_wr_half = 1'b0;
          next_state = cmd_in.write ? sam_pkg::ST_WRITE : sam_pkg::ST_READ;
        end
      end
      sam_pkg::ST_READ: begin
        if (push) begin
          next_k = k + 2'h1;
          if (k == wm1) begin
            next_state = sam_pkg::ST_IDLE;
          end
        end
      end
      sam_pkg::ST_WRITE: begin
        if (wr_take) begin
          next_wr_half = !wr_half;
          if (!wr_half) begin
            next_hold_d = bd;
            next_hold_m = bm;
          end else begin
            next_k = k + 2'h1;
            if (k == wm1) begin
              next_state = sam_pkg::ST_IDLE;
            end
          end
        end
      end
      default: next_state = sam_pkg::ST_IDLE;
    endcase
    next_cmd_ready = next_state == sam_pkg::ST_IDLE;
    next_wr_ready  = next_state == sam_pkg::ST_WRITE;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state         <= sam_pkg::ST_IDLE;
      k             <= sam_pkg::CNT_RST;
      wm1           <= sam_pkg::CNT_RST;
      ilv           <= 1'b0;
      spair         <= 1'b0;
      bank          <= '0;
      row           <= '0;
      colw          <= '0;
      hold_d        <= '0;
      hold_m        <= '0;
      wr_half       <= 1'b0;
      cmd_ready_out <= sam_pkg::READY_RST;
      wr_ready_out  <= sam_pkg::READY_RST;
    end else begin
      state         <= next_state;
      k             <= next_k;
      wm1           <= next_wm1;
      ilv           <= next_ilv;
      spair         <= next_spair;
      bank          <= next_bank;
      row           <= next_row;
      colw          <= next_colw;
      hold_d        <= next_hold_d;
      hold_m        <= next_hold_m;
      wr_half       <= next_wr_half;
      cmd_ready_out <= next_cmd_ready;
      wr_ready_out  <= next_wr_ready;
    end
  end

  // Masked bytes keep their old content
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      for (int b = 0; b < 4 * LN; b++) begin
        if (!wmask[b]) begin
          mem[mem_idx][b*8 +: 8] <= wword[b*8 +: 8]; // [R05] [R13]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer and DDR serializer; a stalled receiver back-pressures the core reads
  logic [WW:0]              fifo [2];
  logic                     rptr, wptr, ser_half, next_ser_half, load, pop, pidx;
  logic [WW:0]              head;
  logic [2*N-1:0]           pd;
  sam_pkg::sam_rbeat_type   next_rd_beat;
  logic                     next_rd_valid, next_dq_oe, next_flag, next_flag_oe;

  assign head = fifo[rptr];
  assign load = !rd_valid_out || rd_ready_in;
  assign pop  = load && fcnt != 2'h0 && ser_half; // [R05]
  assign pidx = head[WW] ^ ser_half;
  assign pd   = pidx ? head[2*N +: 2*N] : head[0 +: 2*N];

  always_ff @(posedge clk_in) begin
    if (push) begin
      fifo[wptr] <= {spair, mem[mem_idx]}; // [R05]
    end
  end

  always_comb begin
    next_fcnt     = fcnt + 2'(push) - 2'(pop);
    next_rd_valid = rd_valid_out;
    next_rd_beat  = rd_beat_out;
    next_ser_half = ser_half;
    if (load) begin
      next_rd_valid = fcnt != 2'h0;
      if (fcnt != 2'h0) begin
        next_rd_beat.rise = sam_pkg::DQ_MAX'(pd[N-1:0]); // [R06]
        next_rd_beat.fall = sam_pkg::DQ_MAX'(pd[2*N-1:N]); // [R06]
        next_ser_half     = !ser_half;
      end
    end
    next_dq_oe   = next_rd_valid && !hiz_active; // [R08]
    next_flag    = temp_s2 >= sam_pkg::HOT_LIMIT_C; // [R10]
    next_flag_oe = !hiz_active; // [R08]
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fcnt                         <= sam_pkg::CNT_RST;
      rptr                         <= 1'b0;
      wptr                         <= 1'b0;
      ser_half                     <= 1'b0;
      rd_valid_out                 <= 1'b0;
      rd_beat_out                  <= '0;
      dq_oe_out                    <= 1'b0;
      over_temperature_flag_out    <= sam_pkg::FLAG_RST;
      over_temperature_flag_oe_out <= 1'b0;
    end else begin
      fcnt                         <= next_fcnt;
      rptr                         <= rptr ^ pop;
      wptr                         <= wptr ^ push;
      ser_half                     <= next_ser_half;
      rd_valid_out                 <= next_rd_valid;
      rd_beat_out                  <= next_rd_beat;
      dq_oe_out                    <= next_dq_oe;
      over_temperature_flag_out    <= next_flag;
      over_temperature_flag_oe_out <= next_flag_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [2:0] push_cnt;
  always_ff @(posedge clk_in) begin
    if (rst_in || cmd_take) begin
      push_cnt <= 3'h0;
    end else if (push) begin
      push_cnt <= push_cnt + 3'h1;
    end
  end

  chk_hiz_outputs: assert property (@(posedge clk_in) disable iff (rst_in) // [R08]
    hiz_active |=> !dq_oe_out && !over_temperature_flag_oe_out) else $error("outputs driven in tristate");
  chk_hiz_pin_path: assert property (@(posedge clk_in) disable iff (rst_in) // [R09]
    (force_outputs_tristate_in ^ tristate_invert_fuse_in)[*4] |-> !over_temperature_flag_oe_out)
    else $error("active tristate pin not obeyed");
  chk_temp_hot: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    ($signed(die_temp_in) >= 8'sh55)[*4] |-> over_temperature_flag_out) else $error("alarm low when hot");
  chk_temp_cool: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    ($signed(die_temp_in) < 8'sh55)[*4] |-> !over_temperature_flag_out) else $error("alarm high when cool");
  chk_burst_words: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    $fell(state == sam_pkg::ST_READ) |-> push_cnt == 3'(wm1) + 3'h1) else $error("wrong burst word count");
  chk_pop_spacing: assert property (@(posedge clk_in) disable iff (rst_in) // [R05]
    pop |=> !pop) else $error("core word left in under two beats");
  chk_beat_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [R06]
    rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_beat_out)) else $error("stalled beat changed");
  chk_mask_keeps: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    mem_we && wmask[0] |=> mem[$past(mem_idx)][7:0] == $past(mem[mem_idx][7:0])) else $error("masked byte written");
  chk_unmasked_writes: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    mem_we && !wmask[0] |=> mem[$past(mem_idx)][7:0] == $past(wword[7:0])) else $error("byte not written");
  chk_take_start: assert property (@(posedge clk_in) disable iff (rst_in) // [R03]
    cmd_take |=> spair == $past(cmd_in.col[1]) && !cmd_ready_out) else $error("start column not latched");

  cov_read_bl16: cover property (@(posedge clk_in) disable iff (rst_in)
    cmd_take && !cmd_in.write && cmd_in.bl == sam_pkg::BL16);
  cov_write_done: cover property (@(posedge clk_in) disable iff (rst_in) mem_we ##1 state == sam_pkg::ST_IDLE);
  cov_full_stall: cover property (@(posedge clk_in) disable iff (rst_in) fcnt == 2'h2 && !rd_ready_in);
  cov_hiz_read: cover property (@(posedge clk_in) disable iff (rst_in) hiz_active && rd_valid_out);
endmodule

// [sam_host_model.sv]
`timescale 1ns/1ns
module sam_host_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pace of the read receiver
  input  wire logic slow_in,
  output logic      rd_ready_out
);
  logic [1:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Slow mode refuses one beat in four, so the read buffer must hold words
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt          <= 2'h0;
      rd_ready_out <= 1'b0;
    end else begin
      cnt          <= cnt + 2'h1;
      rd_ready_out <= !slow_in || (cnt != 2'h0);
    end
  end
endmodule

// [test_sdram_address_map_and_prefetch_io.sv]
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_sdram_address_map_and_prefetch_io;
  logic                   clk_in;
  logic                   rst_in;
  sam_pkg::sam_cmd_type   cmd;
  sam_pkg::sam_wbeat_type wbeat;
  sam_pkg::sam_rbeat_type rbeat;
  logic                   wr_valid, cmd_ready, wr_ready, rd_valid, rd_ready, dq_oe;
  logic                   hiz, ot_flag, ot_oe, slow, fuse;
  logic [7:0]             temp;
  logic [31:0]            rnd;
  logic [31:0]            e;
  logic [15:0]            mem [int];
  logic [31:0]            expq [$];
  int                     err_total, check_count;
  logic [7:0]             tv [6] = '{8'h54, 8'h55, 8'hFB, 8'h7F, 8'h00, 8'h64};
  logic                   te [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  sam_core sam_core_inst (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .wr_beat_in(wbeat), .wr_valid_in(wr_valid), .wr_ready_out(wr_ready), .rd_beat_out(rbeat),
    .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .dq_oe_out(dq_oe), .force_outputs_tristate_in(hiz),
    .tristate_invert_fuse_in(fuse), .die_temp_in(temp), .over_temperature_flag_out(ot_flag),
    .over_temperature_flag_oe_out(ot_oe));

  sam_host_model sam_host_model_inst (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .rd_ready_out(rd_ready));

  function automatic logic [31:0] rand32();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction

  task automatic finish_test();
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // r carries bank [2:0], col [13:3], burst code [15:14], interleave [16]
  task automatic send(input logic wr, input logic msk, input logic [31:0] r);
    int n, w, s, o, cw, p, k0;
    logic [31:0] d;
    logic [3:0] m;
    n = 0;
    // Always let an edge pass: ready still reads high in the step of a take
    do begin @(posedge clk_in); n++; end while (cmd_ready !== 1'b1 && n < 300);
    `CHK(cmd_ready, 1'b1, "command slot never opened")
    cmd <= '{valid: 1'b1, cke: 1'b1, cs_n: 1'b0, write: wr, bank: r[2:0], row: {12'(rand32()), 2'h1},
             col: r[13:3], bl: r[15:14], interleave: r[16]};
    @(posedge clk_in);
    cmd.valid <= 1'b0;
    w = (r[15:14] == 2'h3) ? 4 : (r[15:14] == 2'h2) ? 2 : 1;
    cw = r[7:5];
    s = cw & (w - 1);
    for (int k = 0; k < w; k++) begin
      o = r[16] ? (s ^ k) : ((s + k) % w);
      for (int j = 0; j < 2; j++) begin
        p = r[4] ^ j;
        k0 = {r[2:0], 3'((cw & ~(w - 1)) | o), 1'(p), 1'b0};
        if (wr) begin
          d = rand32();
          m = msk ? 4'(rand32()) : 4'h0;
          wbeat <= '{rise: {16'h0, d[15:0]}, fall: {16'h0, d[31:16]}, mask_rise: {2'h0, m[1:0]},
                     mask_fall: {2'h0, m[3:2]}};
          wr_valid <= 1'b1;
          for (int h = 0; h < 2; h++)
            mem[k0 + h] = {m[2 * h + 1] ? mem[k0 + h][15:8] : d[16 * h + 15 -: 8],
                           m[2 * h] ? mem[k0 + h][7:0] : d[16 * h + 7 -: 8]};
          n = 0;
          do begin @(posedge clk_in); n++; end while (wr_ready !== 1'b1 && n < 300);
          `CHK(wr_ready, 1'b1, "write beat not taken")
        end else begin
          expq.push_back({mem[k0 + 1], mem[k0]});
        end
      end
    end
    wr_valid <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((expq.size() != 0 || cmd_ready !== 1'b1) && n < 2000) begin @(posedge clk_in); n++; end
    `CHK(expq.size(), 0, "read beats missing")
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read watcher: every beat taken by the receiver retires the oldest note
  always @(posedge clk_in) begin
    if (rst_in === 1'b0 && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(1'b0, 1'b1, "read beat without request")
      end else begin
        e = expq.pop_front();
        `CHK(rbeat.rise[15:0], e[15:0], "first half data")
        `CHK(rbeat.fall[15:0], e[31:16], "second half data")
        `CHK(dq_oe, ~hiz, "data pin enable")
        `CHK({rbeat.rise[31:16], rbeat.fall[31:16]}, 32'h0, "unused lanes driven")
      end
    end
  end

  initial begin
    #3000000;
    err_total++;
    finish_test();
  end

  initial begin
    rst_in = 1'b1; cmd = '0; wbeat = '0; wr_valid = 1'b0; hiz = 1'b0; slow = 1'b0; temp = 8'h00; fuse = 1'b0;
    rnd = 32'h2B12; err_total = 0; check_count = 0;
    wait_edges(20);
    rst_in <= 1'b0;
    wait_edges(2);
    // Chip select high, then clock enable low: neither may start a burst
    cmd <= '{valid: 1'b1, cke: 1'b1, cs_n: 1'b1, default: '0};
    wait_edges(2);
    `CHK(cmd_ready, 1'b1, "deselected command taken")
    cmd <= '{valid: 1'b1, cke: 1'b0, cs_n: 1'b0, default: '0};
    wait_edges(2);
    `CHK(cmd_ready, 1'b1, "command taken with clock enable low")
    cmd <= '0;
    // Fill every bank, then read back in every code and order
    for (int b = 0; b < 16; b++) send(1'b1, 1'b0, {16'h0, 2'h3, 7'(b >> 3), 4'h0, 3'(b)});
    for (int i = 0; i < 40; i++) begin
      if (i == 20) for (int j = 0; j < 6; j++) send(1'b1, 1'b1, rand32());
      slow <= rnd[9];
      send(1'b0, 1'b0, rand32());
    end
    drain();
    // Tristate input silences both output enables
    hiz <= 1'b1;
    wait_edges(4);
    `CHK(ot_oe, 1'b0, "alarm driven while tristated")
    send(1'b0, 1'b0, {15'h0, 2'h3, 14'h0, 1'b1});
    drain();
    hiz <= 1'b0;
    wait_edges(4);
    `CHK(ot_oe, 1'b1, "alarm pin not restored")
    // Inverted fuse: a low pin now means tristate
    fuse <= 1'b1;
    wait_edges(4);
    `CHK(ot_oe, 1'b0, "low pin ignored with fuse")
    hiz <= 1'b1;
    wait_edges(4);
    `CHK(ot_oe, 1'b1, "high pin tristates with fuse")
    hiz <= 1'b0;
    fuse <= 1'b0;
    wait_edges(4);
    `CHK(ot_oe, 1'b1, "alarm pin after fuse restored")
    for (int i = 0; i < 6; i++) begin
      temp <= tv[i];
      wait_edges(4);
      `CHK(ot_flag, te[i], "temperature alarm level")
    end
    finish_test();
  end
endmodule
